// *** core/lcpl_pkg.sv ***
/*
  Shared constants and helpers for the lamp output, polarity and link controller.
  Assumes eleven lamp channels, byte-wide registers and duty values in whole percent.
*/
package lcpl_pkg;

  localparam int LAMP_COUNT = 11;
  localparam int BYTE_W = 8;
  localparam int HI_W = LAMP_COUNT - BYTE_W;
  localparam int DUTY_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_REQUEST_LO = 8'h73;
  localparam logic [7:0] ADDR_REQUEST_HI = 8'h74;
  localparam logic [7:0] ADDR_POLARITY_LO = 8'h75;
  localparam logic [7:0] ADDR_POLARITY_HI = 8'h76;
  localparam logic [7:0] ADDR_TRANSITION_LO = 8'h77;
  localparam logic [7:0] ADDR_TRANSITION_HI = 8'h78;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [10:0] WORD_RESET = 11'h000;
  localparam logic [10:0] FULL_MASK = 11'h7ff;
  localparam logic [10:0] LO_MASK = 11'h0ff;
  localparam logic [10:0] HI_MASK = 11'h700;
  // channels 1..7 and 9..10 carry a transition bit; 8 and 11 cannot be linked
  localparam logic [10:0] TRANSITION_MASK = 11'h37f;
  localparam logic [10:0] LINKABLE_MASK = 11'h37f;
  localparam int IDX_LAMP9 = 8;
  localparam int IDX_LAMP10 = 9;

  ////////////////////////////////////////////////////////////////////////////
  // duty cycle scale
  localparam logic [6:0] DUTY_FULL = 7'h64;
  localparam logic [6:0] DUTY_ZERO = 7'h00;

  // replace the low or high byte of a lamp-wide word
  function automatic logic [10:0] lcplMerge(logic [10:0] cur, logic [7:0] data, logic isHi);
    logic [10:0] res;
    res = cur;
    if (isHi)
      res[10:8] = data[2:0];
    else
      res[7:0] = data;
    return res;
  endfunction : lcplMerge

  // read back one byte of a lamp-wide word; unused bits read zero
  function automatic logic [7:0] lcplByte(logic [10:0] word, logic isHi);
    logic [7:0] res;
    res = isHi ? {5'h00, word[10:8]} : word[7:0];
    return res;
  endfunction : lcplByte

  function automatic logic [6:0] lcplClampDuty(logic [6:0] duty);
    logic [6:0] res;
    res = (duty > DUTY_FULL) ? DUTY_FULL : duty;
    return res;
  endfunction : lcplClampDuty

endpackage : lcpl_pkg

// *** core/lcpl_cfg_if.sv ***
/*
  Configuration carrier between the register file and the channel logic.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface lcpl_cfg_if;
  logic [10:0] request;
  logic [10:0] polarity;
  logic [10:0] transition;
  logic mirrorLoad;
  logic [10:0] mirrorMask;
  logic [10:0] mirrorValue;

  modport regs (
    output request,
    output polarity,
    output transition,
    output mirrorLoad,
    output mirrorMask,
    output mirrorValue
  );

  modport core (
    input request,
    input polarity,
    input transition,
    input mirrorLoad,
    input mirrorMask,
    input mirrorValue
  );
endinterface : lcpl_cfg_if

// *** core/lcpl_reg_file.sv ***
/*
  Drive request, polarity and link transition registers with byte read-back.
  Assumes a single-cycle write strobe and a read strobe from the host side.
*/
`timescale 1ns/1ps
module lcpl_reg_file (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] regAddr, // register address
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  input wire logic [7:0] regWrData, // write data
  input wire logic polarityMirrorDecouple, // stops polarity writes reaching mirror bits
  output logic [7:0] regRdData, // read data, valid the cycle after regRead
  lcpl_cfg_if.regs cfg // configuration to the channel logic
);
  import lcpl_pkg::*;

  logic isHi;
  logic wrReq;
  logic wrPol;
  logic wrTrn;
  logic [10:0] polNext;

  assign isHi = (regAddr == ADDR_REQUEST_HI) || (regAddr == ADDR_POLARITY_HI) || (regAddr == ADDR_TRANSITION_HI);
  assign wrReq = regWrite && ((regAddr == ADDR_REQUEST_LO) || (regAddr == ADDR_REQUEST_HI));
  assign wrPol = regWrite && ((regAddr == ADDR_POLARITY_LO) || (regAddr == ADDR_POLARITY_HI));
  assign wrTrn = regWrite && ((regAddr == ADDR_TRANSITION_LO) || (regAddr == ADDR_TRANSITION_HI));
  assign polNext = lcplMerge(cfg.polarity, regWrData, isHi);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cfg.request <= WORD_RESET;
    else if (wrReq)
      cfg.request <= lcplMerge(cfg.request, regWrData, isHi) & FULL_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cfg.polarity <= WORD_RESET;
    else if (wrPol)
      cfg.polarity <= polNext;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cfg.transition <= WORD_RESET;
    else if (wrTrn)
      cfg.transition <= lcplMerge(cfg.transition, regWrData, isHi) & TRANSITION_MASK;
  end

  // polarity writes carry over to the mirror bits unless decoupled
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg.mirrorLoad <= 1'b0;
      cfg.mirrorMask <= WORD_RESET;
      cfg.mirrorValue <= WORD_RESET;
    end
    else
    begin
      cfg.mirrorLoad <= wrPol && !polarityMirrorDecouple;
      cfg.mirrorMask <= isHi ? HI_MASK : LO_MASK;
      cfg.mirrorValue <= polNext;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= REG_RESET;
    else if (regRead)
    begin
      unique case (regAddr)
        ADDR_REQUEST_LO, ADDR_REQUEST_HI: regRdData <= lcplByte(cfg.request, isHi);
        ADDR_POLARITY_LO, ADDR_POLARITY_HI: regRdData <= lcplByte(cfg.polarity, isHi);
        ADDR_TRANSITION_LO, ADDR_TRANSITION_HI: regRdData <= lcplByte(cfg.transition, isHi);
        default: regRdData <= REG_RESET;
      endcase
    end
  end
endmodule : lcpl_reg_file

// *** core/lcpl_pin_drive.sv ***
/*
  Turns the logical level of each lamp channel into pin output and enable.
  Assumes the pad resolves the wire from pinOut and pinOe.
*/
`timescale 1ns/1ps
module lcpl_pin_drive #(
  parameter int LAMPS = 11
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [LAMPS-1:0] level, // logical level after polarity
  input wire logic [LAMPS-1:0] pinDirection, // 1 = output
  input wire logic [LAMPS-1:0] pinOutputType, // 1 = push-pull, 0 = open-drain
  output logic [LAMPS-1:0] pinOut, // value driven while enabled
  output logic [LAMPS-1:0] pinOe // high while the pin is driven
);
  import lcpl_pkg::*;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinOut <= WORD_RESET[LAMPS-1:0];
      pinOe <= WORD_RESET[LAMPS-1:0];
    end
    else
    begin
      for (int i = 0; i < LAMPS; i++)
      begin
        // open-drain releases for a high level and leans on the external pull-up
        pinOut[i] <= pinOutputType[i] & level[i];
        pinOe[i] <= pinDirection[i] & (pinOutputType[i] | ~level[i]);
      end
    end
  end
endmodule : lcpl_pin_drive

// *** core/lcpl_lamp_ctrl.sv ***
/*
  Lamp output control: drive requests, polarity, sensor link transitions and a
  direct-behaviour duty cycle generator for eleven lamp pins.
  Assumes touch and link inputs are synchronous to clk_sys, the mirror register
  lives outside and takes the mirror load pulse, and min/max duty are in percent.
*/
`timescale 1ns/1ps
module lcpl_lamp_ctrl
  import lcpl_pkg::*;
#(
  parameter int STEP_DIV = 16
) (
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] regAddr, // register address
  input wire logic regWrite, // register write strobe
  input wire logic regRead, // register read strobe
  input wire logic [7:0] regWrData, // register write data
  output logic [7:0] regRdData, // register read data
  input wire logic [lcpl_pkg::LAMP_COUNT-1:0] pinDirectionSelect, // 1 = pin is an output
  input wire logic [lcpl_pkg::LAMP_COUNT-1:0] pinOutputType, // 1 = push-pull
  input wire logic [lcpl_pkg::LAMP_COUNT-1:0] sensorLink, // per-lamp link to its sensor
  input wire logic [lcpl_pkg::LAMP_COUNT-1:0] touchSensorInput, // touch detected per lamp
  input wire logic invertedLinkTransition, // inverse transition mode
  input wire logic polarityMirrorDecouple, // blocks polarity to mirror copy
  input wire logic [lcpl_pkg::LAMP_COUNT-1:0] dutyReferenceFlip, // mirror bits, duty from 100
  input wire logic [lcpl_pkg::DUTY_W-1:0] minDuty, // minimum duty, percent
  input wire logic [lcpl_pkg::DUTY_W-1:0] maxDuty, // maximum duty, percent
  output logic [lcpl_pkg::LAMP_COUNT-1:0] pinOut, // pin output value
  output logic [lcpl_pkg::LAMP_COUNT-1:0] pinOe, // pin output enable
  output logic [lcpl_pkg::LAMP_COUNT-1:0] lampActuate, // effective actuation per lamp
  output logic mirrorLoad, // one-cycle pulse: load mirror bits
  output logic [lcpl_pkg::LAMP_COUNT-1:0] mirrorMask, // mirror bits to load
  output logic [lcpl_pkg::LAMP_COUNT-1:0] mirrorValue // new mirror values
);
  import lcpl_pkg::*;

  // refused at elaboration: the divider cannot count to zero steps
  if (STEP_DIV < 1)
  begin : g_bad_step_div
    $error("STEP_DIV must be at least one");
  end

  localparam int DIV_W = (STEP_DIV > 1) ? $clog2(STEP_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  lcpl_cfg_if cfg ();

  lcpl_reg_file regFile (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regRead(regRead),
    .regWrData(regWrData),
    .polarityMirrorDecouple(polarityMirrorDecouple),
    .regRdData(regRdData),
    .cfg(cfg.regs)
  );

  assign mirrorLoad = cfg.mirrorLoad;
  assign mirrorMask = cfg.mirrorMask;
  assign mirrorValue = cfg.mirrorValue;

  ////////////////////////////////////////////////////////////////////////////
  // sensor linking

  logic [LAMP_COUNT-1:0] linkRaw;
  logic [LAMP_COUNT-1:0] linkEff;
  logic [LAMP_COUNT-1:0] linkPrev_reg;
  logic [LAMP_COUNT-1:0] linkRise;
  logic [LAMP_COUNT-1:0] holdFlag_reg;
  logic [LAMP_COUNT-1:0] holdFlag_next;
  logic [LAMP_COUNT-1:0] actuate_next;

  always_comb
  begin
    linkRaw = sensorLink & LINKABLE_MASK;
    // the up/down group link on lamp ten drags lamp nine along with it
    linkRaw[IDX_LAMP9] = sensorLink[IDX_LAMP9] | sensorLink[IDX_LAMP10];
    linkEff = linkRaw & pinDirectionSelect;
  end

  assign linkRise = linkEff & ~linkPrev_reg;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      linkPrev_reg <= WORD_RESET;
    else
      linkPrev_reg <= linkEff;
  end

  // hold flag: the lamp kept its host-on state across linking
  always_comb
  begin
    holdFlag_next = holdFlag_reg;
    for (int i = 0; i < LAMP_COUNT; i++)
    begin
      if (!linkEff[i])
        holdFlag_next[i] = 1'b0;
      else if (linkRise[i] && !touchSensorInput[i] && cfg.request[i] && cfg.transition[i])
        holdFlag_next[i] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      holdFlag_reg <= WORD_RESET;
    else
      holdFlag_reg <= holdFlag_next;
  end

  // a linked lamp follows its sensor unless held; without a hold the link itself drops the
  // host-on state, which is the abrupt change that the transition bit avoids
  always_comb
  begin
    actuate_next = WORD_RESET;
    for (int i = 0; i < LAMP_COUNT; i++)
    begin
      if (!pinDirectionSelect[i])
        actuate_next[i] = 1'b0;
      else if (!linkEff[i])
        actuate_next[i] = cfg.request[i];
      else if (!holdFlag_next[i])
        actuate_next[i] = touchSensorInput[i];
      else if (invertedLinkTransition)
        actuate_next[i] = ~touchSensorInput[i];
      else
        actuate_next[i] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      lampActuate <= WORD_RESET;
    else
      lampActuate <= actuate_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty cycle period: 100 steps, one step per divider pulse

  logic [DIV_W-1:0] divCnt_reg;
  logic stepEn;
  logic [DUTY_W-1:0] phaseCnt_reg;
  logic periodEnd;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      divCnt_reg <= DIV_ZERO;
    else if (divCnt_reg == DIV_LAST)
      divCnt_reg <= DIV_ZERO;
    else
      divCnt_reg <= divCnt_reg + DIV_W'(1);
  end

  assign stepEn = (divCnt_reg == DIV_LAST);
  assign periodEnd = (phaseCnt_reg == DUTY_FULL - DUTY_W'(1));

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      phaseCnt_reg <= DUTY_ZERO;
    else if (stepEn)
      phaseCnt_reg <= periodEnd ? DUTY_ZERO : phaseCnt_reg + DUTY_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty mapping and polarity

  logic [DUTY_W-1:0] minClamped;
  logic [DUTY_W-1:0] maxClamped;
  logic [DUTY_W-1:0] dutyEff [LAMP_COUNT];
  logic [DUTY_W-1:0] dutyLatched_reg [LAMP_COUNT];
  logic [LAMP_COUNT-1:0] dutyPhase;
  logic [LAMP_COUNT-1:0] pinLevel;

  assign minClamped = lcplClampDuty(minDuty);
  assign maxClamped = lcplClampDuty(maxDuty);

  always_comb
  begin
    for (int i = 0; i < LAMP_COUNT; i++)
    begin
      logic [DUTY_W-1:0] target;
      target = lampActuate[i] ? maxClamped : minClamped;
      dutyEff[i] = dutyReferenceFlip[i] ? DUTY_FULL - target : target;
    end
  end

  // new duty values take effect at a period boundary so a pulse is never cut
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < LAMP_COUNT; i++)
        dutyLatched_reg[i] <= DUTY_ZERO;
    end
    else if (stepEn && periodEnd)
    begin
      for (int i = 0; i < LAMP_COUNT; i++)
        dutyLatched_reg[i] <= dutyEff[i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < LAMP_COUNT; i++)
    begin
      dutyPhase[i] = (phaseCnt_reg < dutyLatched_reg[i]);
      // polarity alone picks the level; the mirror bit only moved the duty
      pinLevel[i] = cfg.polarity[i] ? dutyPhase[i] : ~dutyPhase[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  lcpl_pin_drive #(
    .LAMPS(LAMP_COUNT)
  ) pinDrive (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .level(pinLevel),
    .pinDirection(pinDirectionSelect),
    .pinOutputType(pinOutputType),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

endmodule : lcpl_lamp_ctrl

// *** verification/lcpl_lamp_ctrl_assertions.sv ***
/* Concurrent checks on the lamp controller top ports.
   Assumes binding to lcpl_lamp_ctrl, one clock clk_sys and reset rst_b. */
`timescale 1ns/1ps
module lcpl_lamp_ctrl_assertions
  import lcpl_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset
  input wire logic [7:0] regAddr, // address
  input wire logic regWrite, // write
  input wire logic regRead, // read
  input wire logic [7:0] regWrData, // write data
  input wire logic [7:0] regRdData, // read data
  input wire logic [10:0] pinDirectionSelect, // direction
  input wire logic [10:0] pinOutputType, // output type
  input wire logic polarityMirrorDecouple, // decouple
  input wire logic [10:0] pinOut, // pin value
  input wire logic [10:0] pinOe, // pin enable
  input wire logic [10:0] lampActuate, // actuation
  input wire logic mirrorLoad, // mirror load
  input wire logic [10:0] mirrorMask, // mirror mask
  input wire logic [10:0] mirrorValue // mirror value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic polWr;
  logic [10:0] ppOut;
  assign polWr = regWrite && (regAddr == ADDR_POLARITY_LO || regAddr == ADDR_POLARITY_HI);
  assign ppOut = pinOutputType & pinDirectionSelect;
  mirror_lo_copy_a:
    assert property (polWr && regAddr == ADDR_POLARITY_LO && !polarityMirrorDecouple |=> mirrorLoad && mirrorMask == LO_MASK)
    else $error("mirror low copy missing");
  mirror_hi_copy_a:
    assert property (polWr && regAddr == ADDR_POLARITY_HI && !polarityMirrorDecouple |=> mirrorLoad && mirrorMask == HI_MASK)
    else $error("mirror high copy missing");
  mirror_lo_value_a:
    assert property (polWr && regAddr == ADDR_POLARITY_LO |=> mirrorValue[7:0] == $past(regWrData))
    else $error("mirror low value differs from written polarity");
  mirror_hi_value_a:
    assert property (polWr && regAddr == ADDR_POLARITY_HI |=> mirrorValue[10:8] == $past(regWrData[2:0]))
    else $error("mirror high value differs from written polarity");
  mirror_blocked_a:
    assert property (polWr && polarityMirrorDecouple |=> !mirrorLoad)
    else $error("mirror copied while decoupled");
  mirror_cause_a:
    assert property (mirrorLoad |-> $past(polWr))
    else $error("mirror load without polarity write");
  input_pin_quiet_a:
    assert property ($stable(pinDirectionSelect) [*3] |-> ((pinOe | lampActuate) & ~pinDirectionSelect) == 11'h000)
    else $error("input pin driven or actuated");
  open_drain_low_a:
    assert property ($stable(pinOutputType) [*3] |-> (pinOut & ~pinOutputType) == 11'h000)
    else $error("open drain pin drives high");
  push_pull_on_a:
    assert property ($stable(ppOut) [*3] |-> (ppOut & ~pinOe) == 11'h000)
    else $error("push pull output released");
  unmapped_zero_a:
    assert property (regRead && (regAddr < ADDR_REQUEST_LO || regAddr > ADDR_TRANSITION_HI) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  trans_hi_bits_a:
    assert property (regRead && regAddr == ADDR_TRANSITION_HI |=> regRdData[7:2] == 6'h00)
    else $error("transition high reserved bits set");
  trans_lo_bit_a:
    assert property (regRead && regAddr == ADDR_TRANSITION_LO |=> !regRdData[7])
    else $error("transition low bit 7 set");
  read_hold_a:
    assert property (!regRead |=> $stable(regRdData))
    else $error("read data changed without read");
  cover property (mirrorLoad);
  cover property (|pinOe);
  cover property (|lampActuate);
endmodule : lcpl_lamp_ctrl_assertions

bind lcpl_lamp_ctrl lcpl_lamp_ctrl_assertions chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
  .pinDirectionSelect(pinDirectionSelect), .pinOutputType(pinOutputType),
  .polarityMirrorDecouple(polarityMirrorDecouple), .pinOut(pinOut), .pinOe(pinOe),
  .lampActuate(lampActuate), .mirrorLoad(mirrorLoad), .mirrorMask(mirrorMask), .mirrorValue(mirrorValue));

// *** verification/lcpl_led_model.sv ***
/* Lamp strings on the pins: pull-up resistor and LED sinking into the pin.
   Assumes pinOut and pinOe of the lamp controller, one clock. */
`timescale 1ns/1ps
module lcpl_led_model (
  input wire logic clk_sys, // clock
  input wire logic clear, // restart on-time count
  input wire logic [10:0] pinOut, // pin value
  input wire logic [10:0] pinOe, // pin enable
  output logic [10:0] pinLevel, // wire level
  output logic [10:0] onCount // lamp one lit cycles
);
  // a released pin floats up through the pull-up, so its lamp is dark
  assign pinLevel = ~pinOe | pinOut;
  always_ff @(posedge clk_sys)
    if (clear)
      onCount <= 11'h000;
    else if (!pinLevel[0])
      onCount <= onCount + 11'h001;
endmodule : lcpl_led_model

// *** verification/tb_lamp_output_polarity_link_ctrl.sv ***
/* Self-checking bench: register access, link transitions, pin drive and duty.
   Assumes lcpl_pkg, the checker bind and the LED model are compiled first. */
`timescale 1ns/1ps
module tb_lamp_output_polarity_link_ctrl;
  import lcpl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [10:0] dirSel = 11'h7ff;
  logic [10:0] outType = 11'h000;
  logic [10:0] link = 11'h000;
  logic [10:0] touch = 11'h000;
  logic [10:0] flip = 11'h000;
  logic invLink = 1'b0;
  logic decouple = 1'b0;
  logic clear = 1'b0;
  logic [6:0] minD = 7'h00;
  logic [6:0] maxD = 7'h64;
  logic [10:0] pinOut, pinOe, actuate, pinLevel, onCount;
  logic [7:0] rbk [7] = '{8'hff, 8'h07, 8'hff, 8'h07, 8'h7f, 8'h03, 8'h00};
  int error_cnt = 0;
  int cmp_count = 0;

  initial forever #4 clk_sys = ~clk_sys;

  lcpl_lamp_ctrl #(.STEP_DIV(1)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .pinDirectionSelect(dirSel), .pinOutputType(outType), .sensorLink(link), .touchSensorInput(touch),
    .invertedLinkTransition(invLink), .polarityMirrorDecouple(decouple), .dutyReferenceFlip(flip),
    .minDuty(minD), .maxDuty(maxD), .pinOut(pinOut), .pinOe(pinOe), .lampActuate(actuate),
    .mirrorLoad(), .mirrorMask(), .mirrorValue());
  lcpl_led_model led_u (.clk_sys(clk_sys), .clear(clear), .pinOut(pinOut), .pinOe(pinOe),
    .pinLevel(pinLevel), .onCount(onCount));

  ////////////////////////////////////////
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    chk({3'h0, regRdData}, {3'h0, e});
  endtask : rd
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////
  initial
  begin
    logic [1:0] lv [3] = '{2'h0, 2'h3, 2'h3};
    logic [1:0] oe [3] = '{2'h3, 2'h2, 2'h2};
    int dt [5] = '{30, 70, 30, 10, 90};
    cyc(5);
    rst_b = 1'b1;
    for (int i = 0; i < 7; i++) rd(ADDR_REQUEST_LO + 8'(i), 8'h00);
    for (int i = 0; i < 6; i++) wr(ADDR_REQUEST_LO + 8'(i), 8'hff);
    for (int i = 0; i < 7; i++) rd(ADDR_REQUEST_LO + 8'(i), rbk[i]);
    chk(actuate, 11'h7ff);
    decouple = 1'b1;
    wr(ADDR_POLARITY_HI, 8'h00);
    decouple = 1'b0;
    wr(ADDR_REQUEST_LO, 8'h80);
    wr(ADDR_REQUEST_HI, 8'h04);
    wr(ADDR_TRANSITION_LO, 8'h00);
    wr(ADDR_TRANSITION_HI, 8'h00);
    link = 11'h7ff;
    cyc(3);
    chk(actuate, 11'h480);
    touch = 11'h7ff;
    cyc(3);
    chk(actuate, 11'h7ff);
    link = 11'h200;
    touch = 11'h100;
    cyc(3);
    chk(actuate, 11'h580);
    dirSel = 11'h77e;
    link = 11'h201;
    touch = 11'h101;
    cyc(3);
    chk(actuate, 11'h500);
    chk(pinOe & 11'h081, 11'h000);
    dirSel = 11'h7ff;
    for (int m = 0; m < 3; m++)
    begin
      link = 11'h000;
      touch = 11'h000;
      invLink = (m == 2);
      wr(ADDR_TRANSITION_LO, (m != 0) ? 8'h04 : 8'h00);
      wr(ADDR_REQUEST_LO, 8'h04);
      cyc(3);
      link = 11'h004;
      cyc(3);
      chk(actuate & 11'h004, (m != 0) ? 11'h004 : 11'h000);
      touch = 11'h004;
      cyc(3);
      chk(actuate & 11'h004, (m != 2) ? 11'h004 : 11'h000);
    end
    link = 11'h000;
    touch = 11'h000;
    outType = 11'h002;
    for (int r = 0; r < 3; r++)
    begin
      wr(ADDR_REQUEST_LO, (r < 2) ? 8'h03 : 8'h00);
      wr(ADDR_POLARITY_LO, (r == 1) ? 8'h03 : 8'h00);
      cyc(250);
      chk(pinLevel & 11'h003, {9'h000, lv[r]});
      chk(pinOe & 11'h003, {9'h000, oe[r]});
    end
    maxD = 7'h1e;
    minD = 7'h0a;
    for (int r = 0; r < 5; r++)
    begin
      wr(ADDR_REQUEST_LO, (r < 3) ? 8'h01 : 8'h00);
      wr(ADDR_POLARITY_LO, (r == 1 || r == 2 || r == 4) ? 8'h01 : 8'h00);
      flip = (r == 2) ? 11'h001 : 11'h000;
      cyc(250);
      clear = 1'b1;
      cyc(1);
      clear = 1'b0;
      cyc(100);
      chk(onCount, 11'(dt[r]));
    end
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule : tb_lamp_output_polarity_link_ctrl
